// ==== motor_trig_adc_pkg.sv ====
// Purpose: Shared constants and types for the motor-trigger conversion program selector.
// Assumes: One 20 MHz clock, AXI4-Lite register access with 32-bit data.
// Notes: Offsets are byte addresses; each register is one aligned word.
//
// How it works
// - Bit 7 of each trigger select register enables its motor trigger; a cleared bit ignores it.
// - Trigger select registers for triggers zero to five govern motor_trigger_0 to motor_trigger_5.
// - Bits 2-0 of a trigger select pick program zero to five; codes 110 and 111 are reserved.
// - Interrupt choice 10 raises the conversion-done interrupt, 00 and 11 raise none, 01 is reserved.
// - Interrupt select register n governs the completion interrupt of program n when it finishes.
// - Each program register holds four slots, each an enable and a five-bit input select.
// - A running program converts each enabled slot whose input code is nine to twelve and passes its slot number as the result index.
// - Input codes 0_1001 to 0_1100 select analog inputs nine to twelve; all others are reserved.
// - Slot m has its enable at bit 8m+7 and its input select at bits 8m+4 down to 8m.
// - Conversion starts come from the motor trigger lines as well as from software.
package motor_trig_adc_pkg;
  localparam int NUM_TRIG = 6;
  localparam int NUM_PROG = 6;
  localparam int NUM_SLOT = 4;
  localparam int ADDR_W = 8;
  localparam logic [7:0] TRIG_SEL_BASE = 8'h00;
  localparam logic [7:0] IRQ_SEL_BASE = 8'h20;
  localparam logic [7:0] PROG_SLOT_BASE = 8'h40;
  localparam logic [7:0] INT_STATUS_OFS = 8'h60;
  localparam logic [7:0] INT_MASK_OFS = 8'h64;
  localparam logic [7:0] SW_START_OFS = 8'h68;
  localparam logic [7:0] RUN_STATE_OFS = 8'h6c;
  localparam int TRIG_EN_BIT = 7;
  localparam int SLOT_STRIDE = 8;
  localparam int SLOT_EN_POS = 7;
  localparam int DONE_LSB = 0;
  localparam int OVERRUN_LSB = 8;
  localparam int RUN_SLOT_LSB = 4;
  localparam int RUN_BUSY_BIT = 8;
  localparam int RUN_PEND_LSB = 16;
  localparam logic [31:0] TRIG_SEL_WMASK = 32'h0000_0087;
  localparam logic [31:0] IRQ_SEL_WMASK = 32'h0000_0003;
  localparam logic [31:0] PROG_SLOT_WMASK = 32'h9f9f_9f9f;
  localparam logic [31:0] INT_WMASK = 32'h0000_3f3f;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [2:0] PROG_NUM_LAST = 3'h5;
  localparam logic [1:0] IRQ_CHOICE_FIRE = 2'h2;
  localparam logic [4:0] AIN_FIRST = 5'h09;
  localparam logic [4:0] AIN_LAST = 5'h0c;
  localparam logic [1:0] SLOT_LAST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SCAN, SEQ_WAIT, SEQ_FINISH} seq_state_t;

  // One conversion request towards the converter core.
  typedef struct packed {
    logic start;
    logic [4:0] input_sel;
    logic [1:0] result_idx;
  } conv_req_t;
endpackage

// ==== motor_trig_adc.sv ====
// Purpose: Starts preset conversion programs from six motor-drive trigger lines.
// Assumes: Trigger and converter handshake inputs are synchronous to sys_clk.
// Notes: Registers are reached over AXI4-Lite; see the package for the map.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module motor_trig_adc
  import motor_trig_adc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_TRIG-1:0] motor_trigger,
  output conv_req_t conv_req,
  input wire logic conv_done,
  output logic motor_conv_done_irq,
  output logic irq
);

  // ********************************************************************
  // Helpers
  // ********************************************************************

  // Slot enable of slot m in a program word.
  function automatic logic slot_enable(input logic [31:0] w, input logic [1:0] m);
    slot_enable = w[SLOT_STRIDE*m + SLOT_EN_POS];
  endfunction

  // Input select of slot m in a program word.
  function automatic logic [4:0] slot_input_select(input logic [31:0] w, input logic [1:0] m);
    slot_input_select = w[SLOT_STRIDE*m +: 5];
  endfunction

  // Byte-lane merge that also drops writes to unused bits.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge = (old & ~lanes) | (d & lanes);
  endfunction

  // ********************************************************************
  // State declarations
  // ********************************************************************

  logic [31:0] trig_sel_r [NUM_TRIG];
  logic [31:0] trig_sel_nxt [NUM_TRIG];
  logic [31:0] irq_sel_r [NUM_PROG];
  logic [31:0] irq_sel_nxt [NUM_PROG];
  logic [31:0] prog_slot_r [NUM_PROG];
  logic [31:0] prog_slot_nxt [NUM_PROG];
  logic [31:0] int_status_r, int_status_nxt;
  logic [31:0] int_mask_r, int_mask_nxt;
  logic irq_r, irq_nxt;

  logic aw_held_r, aw_held_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic w_held_r, w_held_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic wr_fire;
  logic [NUM_TRIG-1:0] sw_start;

  seq_state_t state_r, state_nxt;
  logic [NUM_TRIG-1:0] pending_r, pending_nxt;
  logic [2:0] cur_prog_r, cur_prog_nxt;
  logic [1:0] slot_r, slot_nxt;
  conv_req_t conv_req_r, conv_req_nxt;
  logic done_irq_r, done_irq_nxt;
  logic [NUM_PROG-1:0] done_evt;
  logic [NUM_TRIG-1:0] overrun_evt;

  // ********************************************************************
  // Register file and bus slave
  // ********************************************************************

  // Address decode, writes, reads and sticky status. Only one write and one read are
  // held at a time, which keeps the slave small at the cost of throughput.
  always_comb begin
    logic [ADDR_W-1:0] a;
    logic hit;
    a = '0;
    hit = 1'b0;
    trig_sel_nxt = trig_sel_r;
    irq_sel_nxt = irq_sel_r;
    prog_slot_nxt = prog_slot_r;
    int_mask_nxt = int_mask_r;
    int_status_nxt = int_status_r;
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    sw_start = '0;
    // Address and data are taken in either order.
    if (s_axi_awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    wr_fire = aw_held_r && w_held_r && !bvalid_r;
    if (wr_fire) begin
      a = aw_addr_r;
      hit = 1'b1;
      for (int i = 0; i < NUM_TRIG; i++) begin
        if (a == TRIG_SEL_BASE + 8'(4*i)) begin
          trig_sel_nxt[i] = merge(trig_sel_r[i], w_data_r, w_strb_r, TRIG_SEL_WMASK);
        end
      end
      for (int i = 0; i < NUM_PROG; i++) begin
        if (a == IRQ_SEL_BASE + 8'(4*i)) begin
          irq_sel_nxt[i] = merge(irq_sel_r[i], w_data_r, w_strb_r, IRQ_SEL_WMASK);
        end
        if (a == PROG_SLOT_BASE + 8'(4*i)) begin
          prog_slot_nxt[i] = merge(prog_slot_r[i], w_data_r, w_strb_r, PROG_SLOT_WMASK);
        end
      end
      if (a == INT_STATUS_OFS) begin
        int_status_nxt = int_status_r & ~merge(32'h0, w_data_r, w_strb_r, INT_WMASK);
      end else if (a == INT_MASK_OFS) begin
        int_mask_nxt = merge(int_mask_r, w_data_r, w_strb_r, INT_WMASK);
      end else if (a == SW_START_OFS) begin
        sw_start = w_strb_r[0] ? w_data_r[NUM_TRIG-1:0] : '0;
      end else if (!((a >= TRIG_SEL_BASE && a < TRIG_SEL_BASE + 8'h18)
                  || (a >= IRQ_SEL_BASE && a < IRQ_SEL_BASE + 8'h18)
                  || (a >= PROG_SLOT_BASE && a < PROG_SLOT_BASE + 8'h18)
                  || a == RUN_STATE_OFS) || a[1:0] != 2'h0) begin
        hit = 1'b0;
      end
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = hit ? RESP_OKAY : RESP_DECERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // Events set status after the clear so a same-cycle event is never lost.
    int_status_nxt[DONE_LSB +: NUM_PROG] = int_status_nxt[DONE_LSB +: NUM_PROG] | done_evt;
    int_status_nxt[OVERRUN_LSB +: NUM_TRIG] =
      int_status_nxt[OVERRUN_LSB +: NUM_TRIG] | overrun_evt;
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt = !w_held_nxt && !bvalid_nxt;
    // Reads answer one cycle after the address is taken; unused bits read zero.
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rdata_nxt = 32'h0;
      rresp_nxt = RESP_DECERR;
      for (int i = 0; i < NUM_TRIG; i++) begin
        if (s_axi_araddr == TRIG_SEL_BASE + 8'(4*i)) begin
          rdata_nxt = trig_sel_r[i];
          rresp_nxt = RESP_OKAY;
        end
      end
      for (int i = 0; i < NUM_PROG; i++) begin
        if (s_axi_araddr == IRQ_SEL_BASE + 8'(4*i)) begin
          rdata_nxt = irq_sel_r[i];
          rresp_nxt = RESP_OKAY;
        end
        if (s_axi_araddr == PROG_SLOT_BASE + 8'(4*i)) begin
          rdata_nxt = prog_slot_r[i];
          rresp_nxt = RESP_OKAY;
        end
      end
      if (s_axi_araddr == INT_STATUS_OFS) begin
        rdata_nxt = int_status_r;
        rresp_nxt = RESP_OKAY;
      end else if (s_axi_araddr == INT_MASK_OFS) begin
        rdata_nxt = int_mask_r;
        rresp_nxt = RESP_OKAY;
      end else if (s_axi_araddr == SW_START_OFS) begin
        rresp_nxt = RESP_OKAY;
      end else if (s_axi_araddr == RUN_STATE_OFS) begin
        rdata_nxt[2:0] = cur_prog_r;
        rdata_nxt[RUN_SLOT_LSB +: 2] = slot_r;
        rdata_nxt[RUN_BUSY_BIT] = (state_r != SEQ_IDLE);
        rdata_nxt[RUN_PEND_LSB +: NUM_TRIG] = pending_r;
        rresp_nxt = RESP_OKAY;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
    irq_nxt = |(int_status_nxt & int_mask_nxt);
  end

  // Registers of the bus slave and register file; all fields clear on reset except awready, wready and arready, which set.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_TRIG; i++) begin
        trig_sel_r[i] <= REG_RESET;
      end
      for (int i = 0; i < NUM_PROG; i++) begin
        irq_sel_r[i] <= REG_RESET;
        prog_slot_r[i] <= REG_RESET;
      end
      int_status_r <= REG_RESET;
      int_mask_r <= REG_RESET;
      irq_r <= 1'b0;
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else begin
      trig_sel_r <= trig_sel_nxt;
      irq_sel_r <= irq_sel_nxt;
      prog_slot_r <= prog_slot_nxt;
      int_status_r <= int_status_nxt;
      int_mask_r <= int_mask_nxt;
      irq_r <= irq_nxt;
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // ********************************************************************
  // Program sequencer
  // ********************************************************************

  // Triggers queue as pending bits and run one program at a time. A repeat trigger on
  // a trigger already pending is merged and flagged, since a queue per trigger would
  // cost far more than the controller it feeds.
  always_comb begin
    logic [NUM_TRIG-1:0] trig_req;
    logic [2:0] pick;
    logic [31:0] pw;
    trig_req = '0;
    pick = 3'h0;
    pw = prog_slot_r[cur_prog_r];
    state_nxt = state_r;
    pending_nxt = pending_r;
    cur_prog_nxt = cur_prog_r;
    slot_nxt = slot_r;
    conv_req_nxt = conv_req_r;
    conv_req_nxt.start = 1'b0;
    done_irq_nxt = 1'b0;
    done_evt = '0;
    for (int i = 0; i < NUM_TRIG; i++) begin
      trig_req[i] = (motor_trigger[i] || sw_start[i])
                    && trig_sel_r[i][TRIG_EN_BIT]
                    && trig_sel_r[i][2:0] <= PROG_NUM_LAST;
    end
    overrun_evt = trig_req & pending_r;
    case (state_r)
      SEQ_IDLE: begin
        for (int i = NUM_TRIG - 1; i >= 0; i--) begin
          if (pending_r[i]) begin
            pick = 3'(i);
          end
        end
        if (|pending_r) begin
          pending_nxt[pick] = 1'b0;
          // Settings are read at launch, so a reserved code written meanwhile drops it.
          if (trig_sel_r[pick][2:0] <= PROG_NUM_LAST) begin
            cur_prog_nxt = trig_sel_r[pick][2:0];
            slot_nxt = 2'h0;
            state_nxt = SEQ_SCAN;
          end
        end
      end
      SEQ_SCAN: begin
        if (slot_enable(pw, slot_r)
            && slot_input_select(pw, slot_r) >= AIN_FIRST
            && slot_input_select(pw, slot_r) <= AIN_LAST) begin
          conv_req_nxt.start = 1'b1;
          conv_req_nxt.input_sel = slot_input_select(pw, slot_r);
          conv_req_nxt.result_idx = slot_r;
          state_nxt = SEQ_WAIT;
        end else if (slot_r == SLOT_LAST) begin
          state_nxt = SEQ_FINISH;
        end else begin
          slot_nxt = slot_r + 2'h1;
        end
      end
      SEQ_WAIT: begin
        if (conv_done) begin
          if (slot_r == SLOT_LAST) begin
            state_nxt = SEQ_FINISH;
          end else begin
            slot_nxt = slot_r + 2'h1;
            state_nxt = SEQ_SCAN;
          end
        end
      end
      SEQ_FINISH: begin
        done_evt[cur_prog_r] = 1'b1;
        done_irq_nxt = (irq_sel_r[cur_prog_r][1:0] == IRQ_CHOICE_FIRE);
        state_nxt = SEQ_IDLE;
      end
      default: begin
        state_nxt = SEQ_IDLE;
      end
    endcase
    // New requests are set last so a launch clear never swallows them.
    pending_nxt = pending_nxt | trig_req;
  end

  // Sequencer registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SEQ_IDLE;
      pending_r <= '0;
      cur_prog_r <= 3'h0;
      slot_r <= 2'h0;
      conv_req_r <= '0;
      done_irq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pending_r <= pending_nxt;
      cur_prog_r <= cur_prog_nxt;
      slot_r <= slot_nxt;
      conv_req_r <= conv_req_nxt;
      done_irq_r <= done_irq_nxt;
    end
  end

  // Outputs straight from flip-flops.
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign conv_req = conv_req_r;
  assign motor_conv_done_irq = done_irq_r;
  assign irq = irq_r;

endmodule
`default_nettype wire

// ==== motor_trig_adc_asserts.sv ====
// Purpose: Port-level checks on the conversion request and interrupt outputs.
// Assumes: One clock domain, rst_n active low.
// Notes: A helper flag tracks the one conversion that may be outstanding.
`timescale 1ns/1ps
`default_nettype none
module motor_trig_adc_asserts
  import motor_trig_adc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire conv_req_t conv_req,
  input wire logic conv_done,
  input wire logic motor_conv_done_irq,
  input wire logic irq
);
  // ********************************
  // Helper state and checks
  // ********************************
  // Open conversion flag, set by a start and cleared by the answer.
  logic busy_r;
  logic busy_nxt;
  always_comb begin
    busy_nxt = busy_r;
    if (conv_req.start) begin
      busy_nxt = 1'b1;
    end else if (conv_done) begin
      busy_nxt = 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_start_pulse;
    conv_req.start |=> !conv_req.start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_start_input;
    conv_req.start |-> conv_req.input_sel inside {[AIN_FIRST:AIN_LAST]};
  endproperty
  a_start_input: assert property (p_start_input) else $error("bad input code");
  property p_start_serial;
    conv_req.start |-> !busy_r;
  endproperty
  a_start_serial: assert property (p_start_serial) else $error("start overlaps");
  property p_gap_after_done;
    conv_done |=> !conv_req.start;
  endproperty
  a_gap_after_done: assert property (p_gap_after_done) else $error("start too soon");
  property p_sel_held;
    !conv_req.start |-> $stable(conv_req.input_sel) && $stable(conv_req.result_idx);
  endproperty
  a_sel_held: assert property (p_sel_held) else $error("select moved");
  property p_irq_pulse;
    motor_conv_done_irq |=> !motor_conv_done_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("done pulse too long");
  property p_irq_idle;
    motor_conv_done_irq |-> !busy_r && !conv_req.start;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("done while converting");
  property p_reset_quiet;
    $rose(rst_n) |-> conv_req == '0 && !irq && !motor_conv_done_irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not clear");
endmodule
`default_nettype wire

// ==== conv_model.sv ====
// Purpose: Converter core stand-in that answers each start request.
// Assumes: At most one request is open at a time.
// Notes: lat sets the answer delay, zero giving the fastest answer.
`timescale 1ns/1ps
`default_nettype none
module conv_model
  import motor_trig_adc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire conv_req_t conv_req,
  input wire logic [3:0] lat,
  output logic conv_done
);
  // ********************************
  // Conversion timing
  // ********************************
  // Each start completes once, so every enabled slot with input code nine to twelve gets its result.
  logic [3:0] cnt;
  logic busy;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (conv_req.start) begin
        busy <= 1'b1;
        cnt <= lat;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        conv_done <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== motor_trig_adc_tb.sv ====
// Purpose: Self-checking bench for motor_trig_adc.
// Assumes: Reads and writes never overlap, so one queue holds all answers.
// Notes: Random settings are valid codes; reserved bits carry garbage.
`timescale 1ns/1ps
`default_nettype none
module motor_trig_adc_tb import motor_trig_adc_pkg::*;;
  // ********************************
  // Signals and instances
  // ********************************
  logic sys_clk = 1'b0, rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] motor_trigger = 6'h0, fire, stat;
  logic [3:0] lat = 4'h0;
  logic conv_done, motor_conv_done_irq, irq;
  conv_req_t conv_req;
  logic [15:0] lfsr = 16'hcb2e;
  logic [31:0] cfg [3][6];
  logic [31:0] wm [3];
  logic [7:0] base [3];
  logic [7:0] a;
  logic [31:0] r;
  logic [2:0] p;
  logic [33:0] rsp_q [$];
  logic [7:0] conv_q [$];
  int err_total = 0, n_checks = 0, exp_done = 0, done_cnt = 0, t;
  motor_trig_adc u_motor_trig_adc (.*);
  conv_model u_conv_model (.sys_clk(sys_clk), .rst_n(rst_n), .conv_req(conv_req),
    .lat(lat), .conv_done(conv_done));
  always #25 sys_clk = ~sys_clk;
  // ********************************
  // Tasks
  // ********************************
  function automatic logic [31:0] rnd();
    logic [31:0] v;
    for (int k = 0; k < 32; k++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      v[k] = lfsr[0];
    end
    return v;
  endfunction
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // A spare edge after each transfer keeps release and next request apart.
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    rsp_q.push_back({er, 32'h0});
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic axi_rd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    rsp_q.push_back({er, d});
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Monitor takes the oldest note whenever an answer or a start shows.
  always @(posedge sys_clk) begin
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, rsp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rsp_q.pop_front());
    if (conv_req.start === 1'b1) chk(34'(conv_req), 34'(conv_q.pop_front()));
    if (motor_conv_done_irq === 1'b1) done_cnt++;
  end
  initial begin
    #3000000;
    err_total++;
    results();
  end
  // ********************************
  // Main sequence
  // ********************************
  initial begin
    base = '{TRIG_SEL_BASE, IRQ_SEL_BASE, PROG_SLOT_BASE};
    wm = '{TRIG_SEL_WMASK, IRQ_SEL_WMASK, PROG_SLOT_WMASK};
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    axi_rd(8'h80, 32'h0, RESP_DECERR);
    axi_rd(RUN_STATE_OFS, REG_RESET, RESP_OKAY);
    for (int n = 0; n < 3; n++) begin
      lat <= (n == 1) ? 4'h9 : 4'(n * 3);
      stat = 6'h0;
      for (int i = 0; i < NUM_TRIG; i++) begin
        r = rnd();
        cfg[0][i] = {24'h0, r[7], 4'h0, r[10:8] % 3'h6};
        cfg[1][i] = {30'h0, (r[12:11] == 2'h1) ? 2'h2 : r[12:11]};
        for (int m = 0; m < NUM_SLOT; m++)
          cfg[2][i][8*m +: 8] = {r[16+m], 2'h0, AIN_FIRST + 5'(r[20+2*m +: 2])};
        for (int b = 0; b < 3; b++) begin
          a = base[b] + 8'(4 * i);
          if (n == 0) axi_rd(a, REG_RESET, RESP_OKAY);
          axi_wr(a, cfg[b][i] | (r & ~wm[b]), RESP_OKAY);
          axi_rd(a, cfg[b][i], RESP_OKAY);
        end
      end
      // A misaligned write must not disturb trigger zero's setting.
      axi_wr(8'h02, 32'hffff_ffff, RESP_DECERR);
      axi_rd(TRIG_SEL_BASE, cfg[0][0], RESP_OKAY);
      r = rnd();
      fire = r[5:0];
      // The triggers set in fire start in one cycle; they run one by one, lowest first.
      for (int i = 0; i < NUM_TRIG; i++) begin
        p = cfg[0][i][2:0];
        if (fire[i] && cfg[0][i][TRIG_EN_BIT]) begin
          stat[p] = 1'b1;
          if (cfg[1][p][1:0] == IRQ_CHOICE_FIRE) exp_done++;
          for (int m = 0; m < NUM_SLOT; m++)
            if (cfg[2][p][8*m+7]) conv_q.push_back({1'b1, cfg[2][p][8*m +: 5], 2'(m)});
        end
      end
      // The last pass starts through the software register instead of the pins.
      if (n == 2) begin
        axi_wr(SW_START_OFS, 32'(fire), RESP_OKAY);
      end else begin
        motor_trigger <= fire;
        @(posedge sys_clk);
        motor_trigger <= 6'h0;
      end
      t = 0;
      while ((conv_q.size() != 0 || done_cnt != exp_done) && t < 3000) begin
        @(posedge sys_clk);
        t++;
      end
      // Programs with no enabled slot and no pulse may still be draining.
      repeat (100) @(posedge sys_clk);
      chk(34'(conv_q.size()), 34'h0);
      chk(34'(done_cnt), 34'(exp_done));
      axi_rd(INT_STATUS_OFS, 32'(stat), RESP_OKAY);
      chk(34'(irq), 34'h0);
      axi_wr(INT_MASK_OFS, 32'h3f, RESP_OKAY);
      repeat (2) @(posedge sys_clk);
      chk(34'(irq), 34'(stat != 6'h0));
      axi_wr(INT_STATUS_OFS, 32'(stat), RESP_OKAY);
      axi_wr(INT_MASK_OFS, 32'h0, RESP_OKAY);
      axi_rd(INT_STATUS_OFS, 32'h0, RESP_OKAY);
      chk(34'(irq), 34'h0);
    end
    // Only the strobed byte lane may change.
    s_axi_wstrb <= 4'h2;
    axi_wr(PROG_SLOT_BASE, 32'h8a8a_8a8a, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    axi_rd(PROG_SLOT_BASE, {cfg[2][0][31:16], 8'h8a, cfg[2][0][7:0]}, RESP_OKAY);
    results();
  end
endmodule
bind motor_trig_adc motor_trig_adc_asserts u_motor_trig_adc_asserts (.*);
`default_nettype wire
